// >>> bench/aps_host_model.sv
// host serial master model driving select and serial clock
`timescale 1ns/10ps
module aps_host_model (
	// clock
	input wire logic ref_clk,
	// serial pins
	output logic frame_select_n,
	output logic serial_clk,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic [15:0] rx;
	logic line;
	// a released data line shows the inverse of its last value
	always @(posedge ref_clk) begin
		line <= serial_out_oe ? serial_out : ~line;
	end
	initial begin
		frame_select_n = 1'b1;
		serial_clk = 1'b0;
		line = 1'b0;
		rx = 16'h0000;
	end
	// one frame of n clocks, read before each fall; clock still outside frames
	task automatic frame(input int n);
		@(posedge ref_clk) #1 frame_select_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		for (int k = 0; k < n; k++) begin
			#1 serial_clk = 1'b1;
			repeat (4) @(posedge ref_clk);
			rx = {rx[14:0], line};
			#1 serial_clk = 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		#1 frame_select_n = 1'b1;
		repeat (12) @(posedge ref_clk);
	endtask
endmodule

// >>> bench/aps_sequencer_asserts.sv
// port-level assertions of the power mode sequencer
`timescale 1ns/10ps
module aps_sequencer_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// serial pins
	input wire logic frame_select_n,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	// converter core
	input wire logic sample_strobe,
	input wire logic track_mode,
	input wire logic analog_power_on,
	input wire logic power_ready,
	// result stream
	input wire logic result_ready,
	input wire logic result_valid,
	input wire aps_pkg::aps_result_s result_data
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// frame start seen three edges after the pin falls
	property p_frame_start;
		$fell(frame_select_n) && power_ready |-> ##[2:4] (serial_out_oe && !track_mode);
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame start missing");
	property p_strobe;
		$fell(frame_select_n) && power_ready |-> ##[2:4] sample_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("no sample strobe");
	property p_strobe_pulse;
		sample_strobe |=> !sample_strobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
	property p_first_zero;
		$rose(serial_out_oe) |-> !serial_out;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("first bit not zero");
	property p_float;
		$rose(frame_select_n) |-> ##[0:5] !serial_out_oe;
	endproperty
	a_float: assert property (p_float) else $error("output not floated");
	property p_hold_mode;
		frame_select_n && $past(frame_select_n, 5) |-> $stable(analog_power_on);
	endproperty
	a_hold_mode: assert property (p_hold_mode) else $error("mode changed idle");
	property p_down_not_ready;
		!analog_power_on |-> !power_ready;
	endproperty
	a_down_not_ready: assert property (p_down_not_ready) else $error("ready while down");
	property p_settle;
		$rose(analog_power_on) |-> !power_ready [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("ready too early");
	property p_wake_track;
		$fell(frame_select_n) && !analog_power_on |-> ##[6:10] track_mode;
	endproperty
	a_wake_track: assert property (p_wake_track) else $error("wake frame not tracking");
	property p_track_back;
		$fell(serial_out_oe) && !frame_select_n |-> track_mode;
	endproperty
	a_track_back: assert property (p_track_back) else $error("no track before word end");
	property p_stream_hold;
		result_valid && !result_ready |=> result_valid && $stable(result_data);
	endproperty
	a_stream_hold: assert property (p_stream_hold) else $error("result not held");
	// main scenarios
	c_taken: cover property (result_valid && result_ready);
	c_down: cover property ($fell(analog_power_on));
	c_up: cover property ($rose(power_ready));
endmodule

// >>> bench/aps_sequencer_tb_top.sv
// self-checking bench of the power mode sequencer
`timescale 1ns/10ps
module aps_sequencer_tb_top;
	logic ref_clk, reset_n, frame_select_n, serial_clk, serial_out, serial_out_oe;
	logic sample_strobe, track_mode, analog_power_on, power_ready;
	logic result_ready, result_valid, result_space;
	logic [11:0] conv_code;
	aps_pkg::aps_result_s result_data;
	aps_pkg::aps_result_s got[$];
	int fails = 0;
	int comparisons = 0;
	aps_sequencer i_aps_sequencer (.ref_clk(ref_clk), .reset_n(reset_n),
		.frame_select_n(frame_select_n), .serial_clk(serial_clk), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .conv_code(conv_code), .sample_strobe(sample_strobe),
		.track_mode(track_mode), .analog_power_on(analog_power_on), .power_ready(power_ready),
		.result_ready(result_ready), .result_valid(result_valid), .result_data(result_data),
		.result_space(result_space));
	aps_host_model i_aps_host_model (.ref_clk(ref_clk), .frame_select_n(frame_select_n),
		.serial_clk(serial_clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// collect results taken by the reader
	always @(posedge ref_clk) begin
		if (result_valid && result_ready) got.push_back(result_data);
	end
	task automatic chk(input string n, input logic [27:0] e, input logic [27:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// full frame in normal mode: word on the wire and one stream entry
	task automatic t_normal();
		#1 conv_code = 12'hA5C;
		got.delete();
		i_aps_host_model.frame(16);
		chk("wire word", 28'h0000A5C, 28'(i_aps_host_model.rx));
		chk("pushed", 28'h1, 28'(got.size()));
		chk("code", 28'hA5C, 28'(got[0].code));
		chk("word", 28'h0A5C, 28'(got[0].word));
		chk("power", 28'h1, 28'(analog_power_on));
		$display("test normal done");
	endtask
	// select rise after n falls, starting in normal or in power-down
	task automatic t_mode(input int n, input bit from_down, input bit on);
		if (from_down) i_aps_host_model.frame(5);
		got.delete();
		i_aps_host_model.frame(n);
		chk("power", 28'(on), 28'(analog_power_on));
		chk("ready", 28'(on), 28'(power_ready));
		chk("oe", 28'h0, 28'(serial_out_oe));
		chk("no push", 28'h0, 28'(got.size()));
		$display("test mode %0d %0d done", n, from_down);
	endtask
	// reader stalls: two words kept, third dropped, then drained
	task automatic t_buffer();
		got.delete();
		for (int i = 0; i < 3; i++) begin
			#1 conv_code = 12'h100 + 12'(i);
			result_ready = 1'b0;
			i_aps_host_model.frame(16);
		end
		chk("space", 28'h0, 28'(result_space));
		chk("held", 28'h0, 28'(got.size()));
		#1 result_ready = 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("drained", 28'h2, 28'(got.size()));
		chk("first", 28'h100, 28'(got[0].code));
		chk("second", 28'h101, 28'(got[1].code));
		chk("empty", 28'h0, 28'(result_valid));
		$display("test buffer done");
	endtask
	initial begin
		reset_n = 1'b0;
		conv_code = 12'h000;
		result_ready = 1'b1;
		repeat (12) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		chk("track at reset", 28'h1, 28'(track_mode));
		chk("space at reset", 28'h1, 28'(result_space));
		i_aps_host_model.frame(16);
		t_normal();
		t_mode(1, 1'b0, 1'b1);
		t_mode(12, 1'b0, 1'b1);
		t_mode(5, 1'b0, 1'b0);
		t_mode(1, 1'b1, 1'b0);
		t_mode(8, 1'b1, 1'b0);
		t_mode(11, 1'b1, 1'b1);
		t_mode(16, 1'b1, 1'b1);
		t_buffer();
		final_report();
	end
	// watchdog against a hang
	initial begin
		#2000000;
		fails++;
		final_report();
	end
endmodule
bind aps_sequencer aps_sequencer_asserts i_aps_sequencer_asserts (.ref_clk(ref_clk),
	.reset_n(reset_n), .frame_select_n(frame_select_n), .serial_out(serial_out),
	.serial_out_oe(serial_out_oe), .sample_strobe(sample_strobe), .track_mode(track_mode),
	.analog_power_on(analog_power_on), .power_ready(power_ready),
	.result_ready(result_ready), .result_valid(result_valid), .result_data(result_data));

// >>> common/aps_params.svh
// timing counts, edge numbers and word layout of the power mode sequencer
`ifndef APS_PARAMS_SVH
`define APS_PARAMS_SVH

// serial word layout
`define APS_WORD_BITS 16
`define APS_LEAD_ZEROS 4
`define APS_CODE_BITS 12

// serial clock falling edge numbers within a frame
`define APS_EDGE_GLITCH 5'h02
`define APS_EDGE_KEEP 5'h0A
`define APS_EDGE_TRACK 5'h0D
`define APS_EDGE_LATCH 5'h03
`define APS_EDGE_WORD 5'h10
`define APS_EDGE_FULL12 5'h10
`define APS_EDGE_FULL10 5'h0E
`define APS_EDGE_MAX 5'h1F

// analog power-up time and its count of ref_clk cycles
`define APS_CLK_PERIOD_NS 100
`define APS_POWER_UP_NS 1000
`define APS_POWER_UP_CYCLES ((`APS_POWER_UP_NS + `APS_CLK_PERIOD_NS - 1) / `APS_CLK_PERIOD_NS)

`endif

// >>> common/aps_pkg.sv
// types shared by the power mode sequencer, its assertions and its bench
package aps_pkg;

	// power state of the converter
	typedef enum logic [1:0] {
		APS_MODE_NORMAL,
		APS_MODE_WAKING,
		APS_MODE_DOWN
	} aps_mode_e;

	// one finished conversion as handed to the parallel result port
	typedef struct packed {
		logic [11:0] code;
		logic [15:0] word;
	} aps_result_s;

endpackage

// >>> rtl/aps_result_buf.sv
// two-entry skid buffer between the converter and the result port
`timescale 1ns/10ps

module aps_result_buf #(
	parameter int WIDTH = 28
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	input wire logic out_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data
);

	// entry 0 is the head seen at the output, entry 1 the skid slot
	logic [WIDTH-1:0] mem [2];
	logic [1:0] held;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// occupancy and entry moves; head refills from skid on a pop
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			held <= 2'h0;
			mem[0] <= '0;
			mem[1] <= '0;
		end else begin
			unique case ({push, pop})
				2'b10: begin
					if (held == 2'h0) begin
						mem[0] <= in_data;
					end else begin
						mem[1] <= in_data;
					end
					held <= held + 2'h1;
				end
				2'b01: begin
					mem[0] <= mem[1];
					held <= held - 2'h1;
				end
				2'b11: begin
					if (held == 2'h1) begin
						mem[0] <= in_data;
					end else begin
						mem[0] <= mem[1];
						mem[1] <= in_data;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// registered flags so ready and valid come straight from flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			unique case ({push, pop})
				2'b10: begin
					out_valid <= 1'b1;
					in_ready <= (held == 2'h0);
				end
				2'b01: begin
					out_valid <= (held == 2'h2);
					in_ready <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	assign out_data = mem[0];

endmodule

// >>> rtl/aps_sequencer.sv
// frame select and serial clock sequencer of a serial sar converter
`timescale 1ns/10ps
`include "aps_params.svh"

// Behaviour
// [R1] count of clock falls picks power mode
// [R2] sample and start converting at select fall
// [R3] host keeps select low ten falls
// [R4] rise after tenth: stay up, abort, float
// [R5] host gives sixteen or fourteen clocks
// [R6] host may idle select high or low
// [R7] host waits quiet time before next frame
// [R8] power-down turns analog circuitry off
// [R9] rise between second and tenth: power down
// [R10] rise before second fall: stay normal
// [R11] wake starts at fall, needs ten falls
// [R12] dummy wake frame full after sixteen clocks
// [R13] early rise in wake frame: back down
// [R14] host may shorten dummy after power-up time
// [R15] host waits quiet time after dummy frame
// [R16] waking hold returns to track first edge
// [R17] host runs one dummy frame at start
// [R18] host may force power-down at start
// [R19] start-up dummy frame needs no wait
// [R20] track-and-hold starts in track mode
// [R21] sixteen-bit word, four zeros, msb first
// [R22] select fall holds and enables output
// [R23] first zero at select fall, shift falls
// [R24] after thirteen falls track on rise
// [R25] falls counted from select fall, judged rising
// [R26] power state kept while select high
module aps_sequencer #(
	parameter int RESULT_BITS = 12,
	parameter bit START_DOWN = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// serial pins from the host
	input wire logic frame_select_n,
	input wire logic serial_clk,
	// serial data pin, enable high while driving
	output logic serial_out,
	output logic serial_out_oe,
	// converter core
	input wire logic [11:0] conv_code,
	output logic sample_strobe,
	output logic track_mode,
	output logic analog_power_on,
	output logic power_ready,
	// parallel result stream
	input wire logic result_ready,
	output logic result_valid,
	output aps_pkg::aps_result_s result_data,
	output logic result_space
);

	localparam logic [4:0] FULL_EDGE = (RESULT_BITS == 10) ? `APS_EDGE_FULL10 : `APS_EDGE_FULL12;
	localparam logic [3:0] SETTLE_CYCLES = 4'(`APS_POWER_UP_CYCLES);

	// pin synchronisers and edge history
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic sck_meta;
	logic sck_sync;
	logic sck_prev;
	logic cs_fall;
	logic cs_rise;
	logic sck_fall;
	logic sck_rise;

	// frame state
	logic frame_on;
	logic [4:0] edge_cnt;
	logic [4:0] next_cnt;
	logic [11:0] code_q;
	logic frame_normal;
	logic wake_tracked;
	aps_pkg::aps_mode_e mode;
	aps_pkg::aps_mode_e next_mode;
	logic [3:0] settle_cnt;
	logic [15:0] out_word;

	// result push into the buffer
	logic push_valid;
	aps_pkg::aps_result_s push_data;
	logic buf_ready;

	// serial word: leading zeros, code msb first, trailing zeros for 10 bits
	function automatic logic [15:0] build_word(input logic [11:0] c);
		logic [11:0] m;
		m = c;
		if (RESULT_BITS == 10) begin
			m[1:0] = 2'h0;
		end
		return {4'h0, m}; // [R21]
	endfunction

	// power state left by a select rise, judged on the falls counted so far
	function automatic aps_pkg::aps_mode_e rise_mode(input logic [4:0] falls,
			input logic began_normal);
		if (falls < `APS_EDGE_GLITCH) begin
			// glitch: normal stays normal, a wake falls back [R10] [R13]
			return began_normal ? aps_pkg::APS_MODE_NORMAL : aps_pkg::APS_MODE_DOWN;
		end else if (falls < `APS_EDGE_KEEP) begin
			return aps_pkg::APS_MODE_DOWN; // [R9] [R13]
		end
		return aps_pkg::APS_MODE_NORMAL; // [R4] [R11]
	endfunction

	// two flip-flops on each pin before any logic looks at it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
			sck_meta <= 1'b0;
			sck_sync <= 1'b0;
			sck_prev <= 1'b0;
		end else begin
			cs_meta <= frame_select_n;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			sck_meta <= serial_clk;
			sck_sync <= sck_meta;
			sck_prev <= sck_sync;
		end
	end

	assign cs_fall = cs_prev && !cs_sync;
	assign cs_rise = !cs_prev && cs_sync && frame_on; // idle-high rises ignored [R26]
	assign sck_fall = sck_prev && !sck_sync && frame_on;
	assign sck_rise = !sck_prev && sck_sync && frame_on;
	assign next_cnt = (edge_cnt == `APS_EDGE_MAX) ? edge_cnt : edge_cnt + 5'h01;

	// the word shifted out, rebuilt from the latched code
	assign out_word = build_word(code_q);

	// falling edge counter, cleared at each select fall [R25]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_on <= 1'b0;
			edge_cnt <= 5'h00;
		end else if (cs_fall) begin
			frame_on <= 1'b1;
			edge_cnt <= 5'h00;
		end else if (cs_rise) begin
			frame_on <= 1'b0;
		end else if (sck_fall) begin
			edge_cnt <= next_cnt;
		end
	end

	// power mode decision, taken at the select fall, the select rise and the sixteenth fall of a wake frame [R1] [R26]
	always_comb begin
		next_mode = mode;
		if (cs_fall && mode == aps_pkg::APS_MODE_DOWN) begin
			next_mode = aps_pkg::APS_MODE_WAKING; // wake begins at select fall [R11]
		end else if (cs_rise) begin
			next_mode = rise_mode(edge_cnt, frame_normal); // [R1] [R9] [R10]
		end else if (sck_fall && next_cnt == `APS_EDGE_WORD && mode == aps_pkg::APS_MODE_WAKING) begin
			next_mode = aps_pkg::APS_MODE_NORMAL; // full dummy frame done [R12]
		end
	end

	// mode register and analog supply switch
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode <= START_DOWN ? aps_pkg::APS_MODE_DOWN : aps_pkg::APS_MODE_NORMAL;
			analog_power_on <= !START_DOWN;
		end else begin
			mode <= next_mode;
			analog_power_on <= (next_mode != aps_pkg::APS_MODE_DOWN); // [R8]
		end
	end

	// remember whether the frame began fully powered; only such frames yield data
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_normal <= 1'b0;
		end else if (cs_fall) begin
			frame_normal <= (mode == aps_pkg::APS_MODE_NORMAL); // [R12]
		end
	end

	// sample strobe on every select fall [R2]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= cs_fall; // [R2]
		end
	end

	// code from the converter core is taken just before its msb goes out
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			code_q <= 12'h000;
		end else if (sck_fall && next_cnt == `APS_EDGE_LATCH) begin
			code_q <= conv_code;
		end
	end

	// serial data pin: zero at select fall, a new bit on each of the first fifteen clock falls
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (cs_fall) begin
			serial_out <= 1'b0; // first leading zero [R23]
			serial_out_oe <= 1'b1; // leave high impedance [R22]
		end else if (cs_rise) begin
			serial_out_oe <= 1'b0; // aborted frame floats the pin [R4] [R9]
		end else if (sck_fall) begin
			if (next_cnt >= `APS_EDGE_WORD) begin
				serial_out_oe <= 1'b0; // last bit done at sixteenth fall [R23]
			end else begin
				serial_out <= out_word[4'hF - next_cnt[3:0]]; // [R23]
			end
		end
	end

	// track-and-hold control, track from reset [R20]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			track_mode <= 1'b1; // [R20]
		end else if (cs_fall) begin
			track_mode <= 1'b0; // hold at select fall [R22]
		end else if (cs_rise) begin
			track_mode <= (next_mode != aps_pkg::APS_MODE_DOWN);
		end else if (!wake_tracked && (sck_fall || sck_rise)) begin
			track_mode <= 1'b1; // first clock edge of a wake frame [R16]
		end else if (sck_rise && edge_cnt >= `APS_EDGE_TRACK) begin
			track_mode <= 1'b1; // [R24]
		end
	end

	// a wake frame owes one early return to track on its first clock edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_tracked <= 1'b0;
		end else if (cs_fall) begin
			wake_tracked <= (mode != aps_pkg::APS_MODE_DOWN);
		end else if (!cs_rise && (sck_fall || sck_rise)) begin
			wake_tracked <= 1'b1; // [R16]
		end
	end

	// analog settle timer, restarted whenever the analog supply is off
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			settle_cnt <= 4'h0;
		end else if (!analog_power_on) begin
			settle_cnt <= 4'h0;
		end else if (settle_cnt != SETTLE_CYCLES) begin
			settle_cnt <= settle_cnt + 4'h1;
		end
	end

	// ready follows the next mode so it drops in the same cycle as the supply [R8]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			power_ready <= 1'b0;
		end else begin
			power_ready <= (next_mode == aps_pkg::APS_MODE_NORMAL) &&
				(settle_cnt == SETTLE_CYCLES);
		end
	end

	// completed conversion of a powered frame goes to the result buffer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			push_valid <= 1'b0;
			push_data <= '0;
		end else begin
			push_valid <= 1'b0;
			if (sck_fall && next_cnt == FULL_EDGE && frame_normal && buf_ready) begin
				push_valid <= 1'b1; // [R12]
				push_data.code <= code_q;
				push_data.word <= out_word; // [R21]
			end
		end
	end

	// buffer space flag seen one cycle late, registered for the port
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_space <= 1'b1;
		end else begin
			result_space <= buf_ready;
		end
	end

	// two-entry buffer so a stalled reader loses no word until two are held
	aps_result_buf #(
		.WIDTH($bits(aps_pkg::aps_result_s))
	) u_buf (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(push_valid),
		.in_ready(buf_ready),
		.in_data(push_data),
		.out_ready(result_ready),
		.out_valid(result_valid),
		.out_data(result_data)
	);

endmodule
